// >>> common/dma_pkg.sv
package dma_pkg;
    localparam int N_CH   = 4;
    localparam int CH_W   = 2;
    localparam int CODE_W = 8;

    // Word index of a register inside one 32-byte channel window
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_SEL  = 3'h1;
    localparam logic [2:0] REG_STA  = 3'h2;
    localparam logic [2:0] REG_STB  = 3'h3;
    localparam logic [2:0] REG_PAD  = 3'h4;
    localparam logic [2:0] REG_CNT  = 3'h5;

    localparam logic [7:0] GLB_STAT  = 8'h80;
    localparam logic [7:0] GLB_MASK  = 8'h84;
    localparam logic [7:0] GLB_STATE = 8'h88;

    localparam logic [1:0] AM_INC = 2'h0;
    localparam logic [1:0] AM_FIX = 2'h1;
    localparam logic [1:0] AM_PIA = 2'h2;

    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [7:0]  SEL_RST  = 8'h00;
    localparam logic [15:0] ADDR_RST = 16'h0000;

    typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} eng_state_e;

    typedef struct packed {
        logic       force_go;
        logic       pingpong;
        logic       oneshot;
        logic [1:0] amode;
        logic       byte_sz;
        logic       dir;
        logic       en;
    } ch_ctrl_s;

    typedef struct packed {
        logic        valid;
        logic        we;
        logic        byte_sz;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_s;
endpackage

// >>> design/dma_prio_arb.sv
`timescale 1ns/10ps
module dma_prio_arb
#(
    parameter int N  = 4,  // Number of requesters
    parameter int IW = 2   // Index width
)
(
    input  wire logic [N-1:0]  req,     // Requests
    output logic      [IW-1:0] gnt_idx, // Winning index
    output logic               any      // Some request present
);
    always_comb begin
        gnt_idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                gnt_idx = IW'(i);
            end
        end
        any = |req;
    end
endmodule

// >>> design/dma_req_sel.sv
`timescale 1ns/10ps
module dma_req_sel
#(
    parameter int N_SRC  = 256, // Number of interrupt sources
    parameter int CODE_W = 8    // Width of the source code
)
(
    input  wire logic              sys_clk, // System clock
    input  wire logic              reset,   // Asynchronous reset
    input  wire logic [N_SRC-1:0]  src_i,   // Interrupt source levels
    input  wire logic [CODE_W-1:0] code_i,  // Selected source code
    output logic                   req_o    // Request pulse
);
    logic prev_r;
    logic prev_nxt;
    logic cur;

    always_comb begin
        cur      = src_i[code_i];
        prev_nxt = cur;
        req_o    = cur && !prev_r;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    a_req_on_rise: assert property (@(posedge sys_clk) disable iff (reset)
        (src_i[code_i] && $stable(code_i) && !$past(src_i[code_i])) |-> req_o)
        else $error("selected source rose without a request");
endmodule

// >>> design/dma_ctrl_top.sv
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
module dma_ctrl_top
#(
    parameter int N_SRC = 256, // Interrupt source count
    parameter int CNT_W = 14   // Block count width
)
(
    input  wire logic                             sys_clk,  // System clock, 125 MHz
    input  wire logic                             reset,    // Asynchronous reset
    input  wire logic [7:0]                       wb_adr_i, // Wishbone byte address
    input  wire logic [31:0]                      wb_dat_i, // Wishbone write data
    input  wire logic [3:0]                       wb_sel_i, // Wishbone byte lanes
    input  wire logic                             wb_we_i,  // Wishbone write
    input  wire logic                             wb_cyc_i, // Wishbone cycle
    input  wire logic                             wb_stb_i, // Wishbone strobe
    output logic [31:0]                           wb_dat_o, // Wishbone read data
    output logic                                  wb_ack_o, // Wishbone acknowledge
    input  wire logic [N_SRC-1:0]                 irq_src,  // Interrupt source levels
    input  wire logic [dma_pkg::N_CH-1:0][15:0]   pia_addr, // Peripheral supplied address
    output dma_pkg::mem_req_s                     dm_o,     // Data mover request
    input  wire logic                             dm_ack,   // Data mover beat done
    input  wire logic [15:0]                      dm_rdata, // Data mover read data
    output logic                                  irq       // Level interrupt to CPU
);
    import dma_pkg::*;

    logic                ack_r, ack_nxt, irq_r, irq_nxt;
    logic [31:0]         dat_r, dat_nxt, rd_val, wr_val;
    ch_ctrl_s            ctrl_r [N_CH];
    ch_ctrl_s            ctrl_nxt [N_CH];
    logic [CODE_W-1:0]   sel_r [N_CH];
    logic [CODE_W-1:0]   sel_nxt [N_CH];
    logic [15:0]         sta_r [N_CH];
    logic [15:0]         sta_nxt [N_CH];
    logic [15:0]         stb_r [N_CH];
    logic [15:0]         stb_nxt [N_CH];
    logic [15:0]         pad_r [N_CH];
    logic [15:0]         pad_nxt [N_CH];
    logic [15:0]         off_r [N_CH];
    logic [15:0]         off_nxt [N_CH];
    logic [CNT_W-1:0]    cnt_r [N_CH];
    logic [CNT_W-1:0]    cnt_nxt [N_CH];
    logic [CNT_W-1:0]    idx_r [N_CH];
    logic [CNT_W-1:0]    idx_nxt [N_CH];
    logic [N_CH-1:0]     pp_r, pp_nxt, pend_r, pend_nxt;
    logic [N_CH-1:0]     en_vec, run, req_evt, soft_go;
    logic [2*N_CH-1:0]   stat_r, stat_nxt, mask_r, mask_nxt;
    logic [CH_W-1:0]     cur_r, cur_nxt, gnt_idx, ach, a_ch;
    eng_state_e          st_r, st_nxt;
    mem_req_s            dm_r, dm_nxt;
    logic                any_run, blk_end, half_hit, stat_rd, wr_go, rd_go, a_glb;
    logic [2:0]          a_reg;
    logic [15:0]         mem_addr, src_addr, dst_addr, step;

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq      = irq_r;
    assign dm_o     = dm_r;

    // any timer, external or peripheral source
    for (genvar g = 0; g < N_CH; g++) begin : g_sel
        dma_req_sel #(
            .N_SRC  (N_SRC),
            .CODE_W (CODE_W)
        ) u_sel (
            .sys_clk (sys_clk),
            .reset   (reset),
            .src_i   (irq_src),
            .code_i  (sel_r[g]),
            .req_o   (req_evt[g])
        );
    end

    dma_prio_arb #(
        .N  (N_CH),
        .IW (CH_W)
    ) u_arb (
        .req     (run),
        .gnt_idx (gnt_idx),
        .any     (any_run)
    );

    always_comb begin
        a_glb   = wb_adr_i[7];
        a_ch    = wb_adr_i[6:5];
        a_reg   = wb_adr_i[4:2];
        wr_go   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
        rd_go   = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
        stat_rd = rd_go && (wb_adr_i == GLB_STAT);
        for (int i = 0; i < N_CH; i++) begin
            en_vec[i] = ctrl_r[i].en;
        end
        run = pend_r & en_vec;
    end

    // Register read mux; unmapped addresses read as zero
    always_comb begin
        rd_val = '0;
        if (!a_glb) begin
            unique case (a_reg)
                REG_CTRL: rd_val = 32'(ctrl_r[a_ch]);
                REG_SEL:  rd_val = 32'(sel_r[a_ch]);
                REG_STA:  rd_val = 32'(sta_r[a_ch]);
                REG_STB:  rd_val = 32'(stb_r[a_ch]);
                REG_PAD:  rd_val = 32'(pad_r[a_ch]);
                REG_CNT:  rd_val = 32'(cnt_r[a_ch]);
                default:  rd_val = '0;
            endcase
        end else if (wb_adr_i == GLB_STAT) begin
            rd_val = 32'(stat_r);
        end else if (wb_adr_i == GLB_MASK) begin
            rd_val = 32'(mask_r);
        end else if (wb_adr_i == GLB_STATE) begin
            rd_val = 32'({pp_r, pend_r});
        end
    end

    // Register file and bus answer
    always_comb begin
        ctrl_nxt = ctrl_r;
        sel_nxt  = sel_r;
        sta_nxt  = sta_r;
        stb_nxt  = stb_r;
        pad_nxt  = pad_r;
        cnt_nxt  = cnt_r;
        mask_nxt = mask_r;
        soft_go  = '0;
        wr_val   = wmerge(rd_val, wb_dat_i, wb_sel_i);
        ack_nxt  = wb_cyc_i && wb_stb_i && !ack_r;
        dat_nxt  = rd_go ? rd_val : '0;
        irq_nxt  = |(stat_r & mask_r);
        if (blk_end && ctrl_r[cur_r].oneshot) begin
            ctrl_nxt[cur_r].en = 1'b0;
        end
        // A software write to the channel's REG_CTRL in the same cycle overrides the hardware disable
        if (wr_go && !a_glb) begin
            unique case (a_reg)
                REG_CTRL: begin
                    ctrl_nxt[a_ch]          = ch_ctrl_s'(wr_val[7:0]);
                    ctrl_nxt[a_ch].force_go = 1'b0;
                    soft_go[a_ch]           = wr_val[7] && wr_val[0];
                end
                REG_SEL:  sel_nxt[a_ch] = wr_val[CODE_W-1:0];
                REG_STA:  sta_nxt[a_ch] = wr_val[15:0];
                REG_STB:  stb_nxt[a_ch] = wr_val[15:0];
                REG_PAD:  pad_nxt[a_ch] = wr_val[15:0];
                REG_CNT:  cnt_nxt[a_ch] = wr_val[CNT_W-1:0];
                default: ;
            endcase
        end else if (wr_go && wb_adr_i == GLB_MASK) begin
            mask_nxt = wr_val[2*N_CH-1:0];
        end
    end

    // Address generation for the channel being served
    always_comb begin
        ach  = (st_r == ST_IDLE) ? gnt_idx : cur_r;
        step = ctrl_r[ach].byte_sz ? STEP_BYTE : STEP_WORD;
        mem_addr = pp_r[ach] ? stb_r[ach] : sta_r[ach];
        if (ctrl_r[ach].amode == AM_INC) begin
            mem_addr = mem_addr + off_r[ach];
        end
        if (ctrl_r[ach].amode == AM_PIA) begin
            mem_addr = pia_addr[ach];
        end
        src_addr = ctrl_r[ach].dir ? mem_addr : pad_r[ach];
        dst_addr = ctrl_r[ach].dir ? pad_r[ach] : mem_addr;
    end

    // Transfer engine
    always_comb begin
        st_nxt   = st_r;
        cur_nxt  = cur_r;
        idx_nxt  = idx_r;
        off_nxt  = off_r;
        pp_nxt   = pp_r;
        dm_nxt   = dm_r;
        stat_nxt = stat_r;
        blk_end  = 1'b0;
        half_hit = idx_r[cur_r] == (cnt_r[cur_r] >> 1);
        if (stat_rd) begin
            stat_nxt = '0;
        end
        pend_nxt = pend_r & en_vec;
        unique case (st_r)
            ST_IDLE: begin
                if (any_run) begin
                    cur_nxt        = gnt_idx;
                    st_nxt         = ST_RD;
                    dm_nxt.valid   = 1'b1;
                    dm_nxt.we      = 1'b0;
                    dm_nxt.byte_sz = ctrl_r[gnt_idx].byte_sz;
                    dm_nxt.addr    = src_addr;
                    dm_nxt.wdata   = '0;
                end
            end
            ST_RD: begin
                if (dm_ack) begin
                    st_nxt      = ST_WR;
                    dm_nxt.we   = 1'b1;
                    dm_nxt.addr = dst_addr;
                    // byte moves clear the upper lane
                    dm_nxt.wdata = ctrl_r[cur_r].byte_sz ? {8'h00, dm_rdata[7:0]} : dm_rdata;
                end
            end
            ST_WR: begin
                if (dm_ack) begin
                    st_nxt          = ST_IDLE;
                    dm_nxt.valid    = 1'b0;
                    dm_nxt.we       = 1'b0;
                    pend_nxt[cur_r] = 1'b0;
                    idx_nxt[cur_r]  = idx_r[cur_r] + CNT_W'(1);
                    if (ctrl_r[cur_r].amode == AM_INC) begin
                        off_nxt[cur_r] = off_r[cur_r] + step;
                    end
                    if (half_hit) begin
                        stat_nxt[N_CH + int'(cur_r)] = 1'b1;
                    end
                    if (idx_r[cur_r] == cnt_r[cur_r]) begin
                        blk_end         = 1'b1;
                        stat_nxt[cur_r] = 1'b1;
                        idx_nxt[cur_r]  = '0;
                        off_nxt[cur_r]  = '0;
                        if (ctrl_r[cur_r].pingpong) begin
                            pp_nxt[cur_r] = !pp_r[cur_r];
                        end
                    end
                end
            end
        endcase
        // soft start carries its own enable; a new request wins over the clear
        pend_nxt = pend_nxt | (req_evt & en_vec) | soft_go;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ack_r  <= 1'b0;
            dat_r  <= '0;
            irq_r  <= 1'b0;
            ctrl_r <= '{default: ch_ctrl_s'(CTRL_RST)};
            sel_r  <= '{default: SEL_RST};
            sta_r  <= '{default: ADDR_RST};
            stb_r  <= '{default: ADDR_RST};
            pad_r  <= '{default: ADDR_RST};
            cnt_r  <= '{default: '0};
            mask_r <= '0;
        end else begin
            ack_r  <= ack_nxt;
            dat_r  <= dat_nxt;
            irq_r  <= irq_nxt;
            ctrl_r <= ctrl_nxt;
            sel_r  <= sel_nxt;
            sta_r  <= sta_nxt;
            stb_r  <= stb_nxt;
            pad_r  <= pad_nxt;
            cnt_r  <= cnt_nxt;
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_r   <= ST_IDLE;
            cur_r  <= '0;
            idx_r  <= '{default: '0};
            off_r  <= '{default: '0};
            pp_r   <= '0;
            pend_r <= '0;
            dm_r   <= '0;
            stat_r <= '0;
        end else begin
            st_r   <= st_nxt;
            cur_r  <= cur_nxt;
            idx_r  <= idx_nxt;
            off_r  <= off_nxt;
            pp_r   <= pp_nxt;
            pend_r <= pend_nxt;
            dm_r   <= dm_nxt;
            stat_r <= stat_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_beat_done;
        st_r == ST_WR && dm_ack;
    endsequence

    sequence s_block_end;
        s_beat_done ##0 blk_end;
    endsequence

    a_lowest_wins: assert property ((st_r == ST_IDLE && run[0]) |=> cur_r == '0)
        else $error("channel 0 pending but not granted");

    a_pend_held: assert property (
        (st_r != ST_WR || !dm_ack) |=> ((($past(run)) & ~pend_r & en_vec) == '0))
        else $error("pending request dropped without service");

    a_dir_source: assert property (
        (st_r == ST_RD && !ctrl_r[cur_r].dir && ctrl_r[cur_r].amode != AM_PIA) |-> dm_o.addr == pad_r[cur_r])
        else $error("peripheral to memory read not from peripheral address");

    a_inc_step: assert property (
        (s_beat_done ##0 (ctrl_r[cur_r].amode == AM_INC && !blk_end))
        |=> off_r[cur_r] == $past(off_r[cur_r]) + $past(step))
        else $error("post increment step wrong");

    a_fix_hold: assert property (
        (s_beat_done ##0 ctrl_r[cur_r].amode == AM_FIX) |=> off_r[cur_r] == $past(off_r[cur_r]))
        else $error("fixed address moved");

    a_pia_dest: assert property (
        (st_r == ST_RD && dm_ack && ctrl_r[cur_r].amode == AM_PIA && !ctrl_r[cur_r].dir)
        |=> dm_o.addr == $past(pia_addr[cur_r]) && dm_o.we)
        else $error("peripheral indirect address not used");

    a_block_flag: assert property (s_block_end |=> stat_r[$past(cur_r)])
        else $error("block done flag not set");

    a_half_flag: assert property (
        (s_beat_done ##0 half_hit) |=> stat_r[N_CH + int'($past(cur_r))])
        else $error("half block flag not set");

    a_byte_lane: assert property (
        (st_r == ST_WR && ctrl_r[cur_r].byte_sz) |-> dm_o.byte_sz && dm_o.wdata[15:8] == 8'h00)
        else $error("byte transfer drives upper lane");

    a_oneshot_off: assert property (
        (s_block_end ##0 (ctrl_r[cur_r].oneshot && !wr_go)) |=> !ctrl_r[$past(cur_r)].en)
        else $error("one-shot channel still enabled");

    a_repeat_on: assert property (
        (s_block_end ##0 (!ctrl_r[cur_r].oneshot && !wr_go)) |=> ctrl_r[$past(cur_r)].en && idx_r[$past(cur_r)] == '0)
        else $error("repeat channel did not restart");

    a_pp_swap: assert property (
        (s_block_end ##0 ctrl_r[cur_r].pingpong) |=> pp_r[$past(cur_r)] != $past(pp_r[cur_r]))
        else $error("ping-pong buffer not swapped");

    a_soft_start: assert property ((soft_go != '0 && st_r == ST_IDLE)
        |=> ((pend_r & $past(soft_go)) == $past(soft_go)) ##1 (st_r != ST_IDLE))
        else $error("software start not registered");
endmodule

// >>> tb/sram_model.sv
`timescale 1ns/10ps
module sram_model
(
    input  wire logic              sys_clk,  // Clock
    input  wire logic              reset,    // Reset
    input  wire dma_pkg::mem_req_s dm_o,     // Mover request
    input  wire logic [3:0]        dly,      // Answer delay
    output logic                   dm_ack,   // Beat done
    output logic [15:0]            dm_rdata, // Read data
    output logic [15:0]            wr_cnt,   // Writes seen
    output logic [15:0]            last_wa,  // Last write address
    output logic [15:0]            last_wd   // Last write data
);
    import dma_pkg::*;
    logic [7:0] mem [256];
    logic [3:0] wait_r;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    // Idle data toggles so a stale value is never taken as valid
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dm_ack <= 1'b0;
            wait_r <= 4'h0;
            wr_cnt <= 16'h0000;
            last_wa <= 16'h0000;
            last_wd <= 16'h0000;
            dm_rdata <= 16'h0000;
        end else if (dm_ack) begin
            dm_ack <= 1'b0;
            dm_rdata <= ~dm_rdata;
            if (dm_o.we) begin
                mem[dm_o.addr[7:0]] <= dm_o.wdata[7:0];
                if (!dm_o.byte_sz) mem[8'(dm_o.addr + 16'h0001)] <= dm_o.wdata[15:8];
                wr_cnt <= wr_cnt + 16'h0001;
                last_wa <= dm_o.addr;
                last_wd <= dm_o.wdata;
            end
        end else if (dm_o.valid && wait_r == dly) begin
            dm_ack <= 1'b1;
            wait_r <= 4'h0;
            dm_rdata <= {mem[8'(dm_o.addr + 16'h0001)], mem[dm_o.addr[7:0]]};
        end else begin
            wait_r <= dm_o.valid ? wait_r + 4'h1 : 4'h0;
            dm_rdata <= ~dm_rdata;
        end
    end
endmodule

// >>> tb/multi_channel_dma_controller_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module multi_channel_dma_controller_tb;
    import dma_pkg::*;
    typedef struct packed {
        logic [1:0] ch;
        logic [1:0] am;
        logic       bsz;
        logic       dir;
        logic [7:0] cnt;
    } row_s;
    logic                  sys_clk = 1'b0;
    logic                  reset   = 1'b1;
    logic [7:0]            adr     = 8'h00;
    logic [31:0]           dat     = 32'h0000_0000;
    logic                  we      = 1'b0;
    logic                  cyc     = 1'b0;
    logic                  stb     = 1'b0;
    logic [255:0]          src     = '0;
    logic [3:0]            dly     = 4'h0;
    logic [N_CH-1:0][15:0] pia;
    logic [31:0]           rd;
    logic                  ack;
    mem_req_s              dm;
    logic                  dm_ack;
    logic [15:0]           dm_rdata;
    logic [15:0]           wr_cnt;
    logic [15:0]           last_wa;
    logic [15:0]           last_wd;
    logic                  irq;
    int                    err_total = 0;
    int                    checked   = 0;
    row_s rows [4] = '{'{2'd0, AM_INC, 1'b0, 1'b0, 8'd3}, '{2'd1, AM_FIX, 1'b1, 1'b0, 8'd1},
                       '{2'd2, AM_PIA, 1'b0, 1'b0, 8'd1}, '{2'd3, AM_INC, 1'b1, 1'b1, 8'd3}};

    always #4 sys_clk = ~sys_clk;

    dma_ctrl_top u_dut (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .wb_adr_i (adr),
        .wb_dat_i (dat),
        .wb_sel_i (4'hf),
        .wb_we_i  (we),
        .wb_cyc_i (cyc),
        .wb_stb_i (stb),
        .wb_dat_o (rd),
        .wb_ack_o (ack),
        .irq_src  (src),
        .pia_addr (pia),
        .dm_o     (dm),
        .dm_ack   (dm_ack),
        .dm_rdata (dm_rdata),
        .irq      (irq)
    );

    sram_model u_mem (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .dm_o     (dm),
        .dly      (dly),
        .dm_ack   (dm_ack),
        .dm_rdata (dm_rdata),
        .wr_cnt   (wr_cnt),
        .last_wa  (last_wa),
        .last_wd  (last_wd)
    );

    task automatic complete_run();
        $display("counts: %0d checked, %0d mismatches", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            err_total++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask

    task automatic wait_wr(input logic [15:0] t);
        for (int n = 0; n < 200 && wr_cnt !== t; n++) @(posedge sys_clk);
        if (wr_cnt !== t) begin
            err_total++;
            complete_run();
        end
    endtask

    task automatic pulse(input logic [7:0] c);
        @(posedge sys_clk);
        src[c] <= 1'b1;
        @(posedge sys_clk);
        src[c] <= 1'b0;
    endtask

    function automatic logic [7:0] ra(input logic [1:0] ch, input logic [2:0] r);
        return {1'b0, ch, r, 2'b00};
    endfunction

    function automatic logic [15:0] rdw(input logic [7:0] a);
        return {8'(a + 8'h01) ^ 8'h5a, a ^ 8'h5a};
    endfunction

    task automatic cfg(input logic [1:0] ch, input ch_ctrl_s c, input logic [7:0] code, input logic [15:0] a,
                       input logic [15:0] b, input logic [7:0] n);
        wr(ra(ch, REG_SEL), {24'h00_0000, code});
        wr(ra(ch, REG_STA), {16'h0000, a});
        wr(ra(ch, REG_STB), {16'h0000, b});
        wr(ra(ch, REG_PAD), {16'h0000, 16'h0010 + 16'(ch) * 16'h0002});
        wr(ra(ch, REG_CNT), {24'h00_0000, n});
        wr(ra(ch, REG_CTRL), {24'h00_0000, c});
    endtask

    initial begin
        logic [15:0] base, sta, pad, sa, dst, ed, step;
        logic [7:0]  code;
        ch_ctrl_s    c;
        row_s        r;
        for (int i = 0; i < N_CH; i++) pia[i] = 16'h0060 + 16'(i * 4);
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        `CHK(irq, 1'b0)
        `CHK(dm.valid, 1'b0)
        rdchk(ra(2'd0, REG_CTRL), 32'h0000_0000);
        rdchk(GLB_STATE, 32'h0000_0000);
        wr(8'h9c, 32'hffff_ffff);
        rdchk(8'h9c, 32'h0000_0000);
        wr(ra(2'd0, REG_SEL), 32'h0000_00a5);
        rdchk(ra(2'd0, REG_SEL), 32'h0000_00a5);
        wr(GLB_MASK, 32'h0000_00ff);
        $display("test registers done");
        foreach (rows[k]) begin
            r = rows[k];
            step = r.bsz ? STEP_BYTE : STEP_WORD;
            sta = 16'h0080 + 16'(r.ch) * 16'h0020;
            pad = 16'h0010 + 16'(r.ch) * 16'h0002;
            code = 8'h10 + 8'(r.ch);
            c = '{1'b0, 1'b0, 1'b1, r.am, r.bsz, r.dir, 1'b1};
            cfg(r.ch, c, code, sta, sta, r.cnt);
            for (int i = 0; i <= r.cnt; i++) begin
                base = wr_cnt;
                pulse(code);
                wait_wr(base + 16'h0001);
                sa = r.dir ? sta + step * 16'(i) : pad;
                dst = r.dir ? pad : r.am == AM_INC ? sta + step * 16'(i) : r.am == AM_FIX ? sta : pia[r.ch];
                ed = rdw(sa[7:0]);
                if (r.bsz) ed[15:8] = 8'h00;
                `CHK(last_wa, dst)
                `CHK(last_wd, ed)
                if (i == r.cnt >> 1) begin
                    repeat (3) @(posedge sys_clk);
                    `CHK(irq, 1'b1)
                    rdchk(GLB_STAT, 32'h0000_0010 << r.ch);
                end
            end
            repeat (3) @(posedge sys_clk);
            rdchk(GLB_STAT, 32'h0000_0001 << r.ch);
            rdchk(ra(r.ch, REG_CTRL), {24'h00_0000, c[7:1], 1'b0});
            base = wr_cnt;
            pulse(code);
            repeat (20) @(posedge sys_clk);
            `CHK(wr_cnt, base)
            $display("test row %0d done", k);
        end
        dly <= 4'h3;
        c = '{1'b0, 1'b0, 1'b1, AM_FIX, 1'b1, 1'b0, 1'b1};
        cfg(2'd2, c, 8'h20, 16'h00c0, 16'h00c0, 8'h00);
        cfg(2'd1, c, 8'h20, 16'h00a0, 16'h00a0, 8'h00);
        base = wr_cnt;
        pulse(8'h20);
        wait_wr(base + 16'h0001);
        `CHK(last_wa, 16'h00a0)
        wait_wr(base + 16'h0002);
        `CHK(last_wa, 16'h00c0)
        $display("test priority done");
        dly <= 4'h0;
        rdchk(GLB_STAT, 32'h0000_0066);
        wr(GLB_MASK, 32'h0000_0000);
        c = '{1'b0, 1'b1, 1'b0, AM_INC, 1'b0, 1'b0, 1'b1};
        cfg(2'd0, c, 8'hff, 16'h0080, 16'h00c8, 8'h00);
        for (int i = 0; i < 3; i++) begin
            base = wr_cnt;
            pulse(8'hff);
            wait_wr(base + 16'h0001);
            `CHK(last_wa, i[0] ? 16'h00c8 : 16'h0080)
        end
        repeat (3) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        wr(GLB_MASK, 32'h0000_0011);
        repeat (3) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        rdchk(GLB_STAT, 32'h0000_0011);
        repeat (3) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        $display("test ping-pong done");
        c = '{1'b1, 1'b0, 1'b1, AM_FIX, 1'b0, 1'b0, 1'b1};
        base = wr_cnt;
        cfg(2'd3, c, 8'h30, 16'h00e0, 16'h00e0, 8'h00);
        wait_wr(base + 16'h0001);
        `CHK(last_wa, 16'h00e0)
        $display("test software start done");
        // Mid-run reset must clear live channel state
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        `CHK(irq, 1'b0)
        rdchk(ra(2'd0, REG_CTRL), 32'h0000_0000);
        rdchk(GLB_STATE, 32'h0000_0000);
        $display("test reset done");
        complete_run();
    end
endmodule
